// >>> src/ces_pkg.sv
package ces_pkg;
   // ----------------------------------------
   // Status word layout
   // ----------------------------------------
   localparam int unsigned SR_T_BIT = 15;
   localparam int unsigned SR_S_BIT = 13;
   localparam int unsigned SR_MASK_LSB = 8;
   localparam int unsigned SR_MASK_MSB = 10;
   localparam logic [15:0] SR_WMASK = 16'hA71F;
   localparam logic [15:0] SR_RST_VAL = 16'h2700;
   localparam logic [2:0] NMI_LEVEL = 3'h7;
   localparam logic [2:0] PIN_IDLE = 3'h7;

   // ----------------------------------------
   // Vector numbers
   // ----------------------------------------
   localparam logic [7:0] VEC_RESET = 8'h00;
   localparam logic [7:0] VEC_BUS = 8'h02;
   localparam logic [7:0] VEC_ADDR = 8'h03;
   localparam logic [7:0] VEC_ILLEGAL = 8'h04;
   localparam logic [7:0] VEC_ZDIV = 8'h05;
   localparam logic [7:0] VEC_CHK = 8'h06;
   localparam logic [7:0] VEC_OVERFLOW_CHECK_INSTRUCTION = 8'h07;
   localparam logic [7:0] VEC_TRACE = 8'h09;
   localparam logic [7:0] VEC_LINEA = 8'h0A;
   localparam logic [7:0] VEC_LINEF = 8'h0B;
   localparam logic [7:0] VEC_SPUR = 8'h18;
   localparam logic [7:0] VEC_AUTO = 8'h18;
   localparam logic [7:0] VEC_TRAP = 8'h20;
   localparam int unsigned VEC_SHIFT = 2;
   localparam int unsigned WORD_SHIFT = 1;
   localparam logic [31:0] WORD_BYTES = 32'h0000_0002;
   localparam logic [3:0] FMT_ZERO = 4'h0;

   // ----------------------------------------
   // Opcode patterns
   // ----------------------------------------
   localparam logic [15:0] OP_ILL_A = 16'h4AFA;
   localparam logic [15:0] OP_ILL_B = 16'h4AFB;
   localparam logic [15:0] OP_ILL_C = 16'h4AFC;
   localparam logic [15:0] OP_BREAKPOINT_INSTRUCTION = 16'h4848;
   localparam logic [15:0] OP_BREAKPOINT_INSTRUCTION_MASK = 16'hFFF8;
   localparam logic [3:0] LINE_A = 4'hA;
   localparam logic [3:0] LINE_F = 4'hF;

   // ----------------------------------------
   // Function codes, word counts, registers
   // ----------------------------------------
   localparam logic [2:0] FC_IDLE = 3'h0;
   localparam logic [2:0] FC_SUP_DATA = 3'h5;
   localparam logic [2:0] FC_SUP_PROG = 3'h6;
   localparam logic [2:0] FC_CPU = 3'h7;
   localparam logic [1:0] VEC_LAST = 2'h1;
   localparam logic [1:0] RST_LAST = 2'h3;
   localparam logic [1:0] RST_SSP_WORD = 2'h1;
   localparam logic [1:0] FRAME_LAST = 2'h3;
   localparam logic [1:0] REG_SR = 2'h0;
   localparam logic [1:0] REG_VBP = 2'h1;
   localparam logic [1:0] REG_SSP = 2'h2;
   localparam logic [1:0] REG_STAT = 2'h3;
   localparam logic [1:0] ACK_VEC = 2'h0;
   localparam logic [1:0] ACK_AUTO = 2'h1;
   localparam logic [1:0] ACK_SPUR = 2'h2;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic valid;
      logic sw_call;
      logic [3:0] sw_num;
      logic overflow_check_instruction;
      logic overflow;
      logic bounds_check_instruction;
      logic out_of_bounds;
      logic signed_divide_instruction;
      logic unsigned_divide_instruction;
      logic divisor_zero;
      logic [31:0] pc;
   } ces_g2_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [31:0] addr;
      logic [15:0] wdata;
      logic [2:0] fc;
   } ces_mem_t;

   typedef struct packed {
      logic [1:0] kind;
      logic [7:0] vector;
   } ces_ack_t;
endpackage : ces_pkg

// >>> src/ces_irq_detect.sv
`timescale 1ns/10ps
`default_nettype none
module ces_irq_detect import ces_pkg::*; (
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [2:0] irq_level_n,
   input wire logic take_nmi,
   output logic [2:0] req_level,
   output logic nmi_pending
);
   logic [2:0] s1_q;
   logic [2:0] s2_q;
   logic [2:0] s3_q;
   logic [2:0] lvl_q;
   logic nmi_q;

   // Level counts only once two stages agree
   wire logic agree = (s2_q == s3_q);
   wire logic [2:0] lvl_d = agree ? ~s3_q : lvl_q;
   wire logic rise7 = (lvl_d == NMI_LEVEL) && (lvl_q != NMI_LEVEL);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s1_q <= PIN_IDLE;
         s2_q <= PIN_IDLE;
         s3_q <= PIN_IDLE;
         lvl_q <= 3'h0;
         nmi_q <= 1'b0;
      end else if (clk_en) begin
         s1_q <= irq_level_n;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
         nmi_q <= rise7 | (nmi_q & ~take_nmi);
      end
   end

   assign req_level = lvl_q;
   assign nmi_pending = nmi_q;
endmodule : ces_irq_detect
`default_nettype wire

// >>> src/ces_ack_unit.sv
`timescale 1ns/10ps
`default_nettype none
module ces_ack_unit import ces_pkg::*; (
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic start,
   input wire logic breakpoint_instruction,
   input wire logic [2:0] level,
   input wire logic transfer_acknowledge_n,
   input wire logic peripheral_address_valid_n,
   input wire logic autovector_request_n,
   input wire logic bus_error_input_n,
   input wire logic [7:0] ack_data,
   output logic ack_strobe,
   output logic [31:0] ack_addr,
   output logic [2:0] function_code_lines,
   output logic done,
   output ces_ack_t result
);
   logic [3:0] s1_q;
   logic [3:0] s2_q;
   logic [3:0] s3_q;
   logic [3:0] resp_q;
   logic active_q;
   logic done_q;
   logic [31:0] addr_q;
   logic [2:0] fc_q;
   ces_ack_t res_q;

   // Response lines: 3 error, 2 auto, 1 valid address, 0 acknowledge
   wire logic [3:0] pins_n = {bus_error_input_n, autovector_request_n,
      peripheral_address_valid_n, transfer_acknowledge_n};
   wire logic [3:0] resp_d = (s2_q == s3_q) ? ~s3_q : resp_q;
   wire logic hit = active_q && (resp_q != 4'h0);
   wire logic [1:0] kind_d = resp_q[3] ? ACK_SPUR :
      (resp_q[2] | resp_q[1]) ? ACK_AUTO : ACK_VEC;
   wire logic [31:0] lvl_addr = 32'({level, 1'b0});

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s1_q <= 4'hF;
         s2_q <= 4'hF;
         s3_q <= 4'hF;
         resp_q <= 4'h0;
         active_q <= 1'b0;
         done_q <= 1'b0;
         addr_q <= 32'h0000_0000;
         fc_q <= FC_IDLE;
         res_q <= '0;
      end else if (clk_en) begin
         s1_q <= pins_n;
         s2_q <= s1_q;
         s3_q <= s2_q;
         resp_q <= resp_d;
         done_q <= hit;
         if (start) begin
            active_q <= 1'b1;
            fc_q <= FC_CPU;
            addr_q <= breakpoint_instruction ? 32'h0000_0000 : lvl_addr;
         end else if (hit) begin
            active_q <= 1'b0;
            fc_q <= FC_IDLE;
            addr_q <= 32'h0000_0000;
            res_q.kind <= kind_d;
            res_q.vector <= ack_data;
         end
      end
   end

   assign ack_strobe = active_q;
   assign ack_addr = addr_q;
   assign function_code_lines = fc_q;
   assign done = done_q;
   assign result = res_q;
endmodule : ces_ack_unit
`default_nettype wire

// >>> src/ces_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module ces_sequencer import ces_pkg::*; #(
   parameter bit HAS_VBR = 1'b1,
   parameter bit HAS_FMT = 1'b1,
   parameter bit HAS_BREAKPOINT_INSTRUCTION = 1'b1,
   parameter int unsigned RST_OUT_CYCLES = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic boundary,
   input wire logic [31:0] boundary_pc,
   input wire logic [15:0] boundary_op,
   input wire logic boundary_op_legal,
   input wire logic trace_done,
   input wire ces_g2_t g2_event,
   input wire logic addr_fault,
   input wire logic bus_fault,
   input wire logic [31:0] fault_pc,
   input wire logic reset_instr,
   output logic busy,
   output logic abort,
   output logic pc_load,
   output logic [31:0] new_pc,
   output logic [15:0] status_reg,
   output logic [31:0] stack_ptr,
   output logic peripheral_reset_out,
   output ces_mem_t mem_cmd,
   input wire logic mem_done,
   input wire logic [15:0] mem_rdata,
   input wire logic [2:0] irq_level_n,
   input wire logic transfer_acknowledge_n,
   input wire logic peripheral_address_valid_n,
   input wire logic autovector_request_n,
   input wire logic bus_error_input_n,
   input wire logic [7:0] ack_data,
   output logic ack_strobe,
   output logic [31:0] ack_addr,
   output logic [2:0] function_code_lines,
   input wire logic [1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);
   localparam int unsigned CW = $clog2(RST_OUT_CYCLES + 1);
   localparam logic [CW-1:0] RST_LOAD = CW'(RST_OUT_CYCLES);

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_IACK = 6'h02,
      ST_BREAKPOINT_INSTRUCTION = 6'h04,
      ST_PUSH = 6'h08,
      ST_VEC = 6'h10,
      ST_LOAD = 6'h20
   } ces_state_t;

   ces_state_t state_q, state_d;
   logic [15:0] sr_q, sr_d;
   logic [15:0] sr_copy_q, sr_copy_d;
   logic [31:0] ssp_q, ssp_d;
   logic [31:0] vbp_q, vbp_d;
   logic [7:0] vec_q, vec_d;
   logic [31:0] pc_save_q, pc_save_d;
   logic [1:0] word_q, word_d;
   logic [31:0] fetch_q, fetch_d;
   logic rst_q, rst_d;
   logic chain_q, chain_d;
   logic [31:0] chain_pc_q, chain_pc_d;
   logic trace_pend_q, trace_pend_d;
   logic [CW-1:0] rcnt_q, rcnt_d;
   logic prst_q;
   logic [31:0] rdata_q;
   logic ack_start;
   logic ack_breakpoint_instruction;
   logic take_nmi;
   logic take_trace;
   logic [2:0] req_level;
   logic [2:0] irq_lvl;
   logic nmi_pending;
   logic ack_done;
   ces_ack_t ack_res;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   ces_irq_detect u_irq (
      .clk(clk),
      .reset(reset),
      .clk_en(clk_en),
      .irq_level_n(irq_level_n),
      .take_nmi(take_nmi),
      .req_level(req_level),
      .nmi_pending(nmi_pending)
   );

   ces_ack_unit u_ack (
      .clk(clk),
      .reset(reset),
      .clk_en(clk_en),
      .start(ack_start),
      .breakpoint_instruction(ack_breakpoint_instruction),
      .level(irq_lvl),
      .transfer_acknowledge_n(transfer_acknowledge_n),
      .peripheral_address_valid_n(peripheral_address_valid_n),
      .autovector_request_n(autovector_request_n),
      .bus_error_input_n(bus_error_input_n),
      .ack_data(ack_data),
      .ack_strobe(ack_strobe),
      .ack_addr(ack_addr),
      .function_code_lines(function_code_lines),
      .done(ack_done),
      .result(ack_res)
   );

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire logic idle = (state_q == ST_IDLE);
   wire logic g0 = addr_fault | bus_fault;
   wire logic at_bound = idle && (boundary || chain_q);
   wire logic [31:0] bpc = chain_q ? chain_pc_q : boundary_pc;
   wire logic [2:0] mask = sr_q[SR_MASK_MSB:SR_MASK_LSB];
   wire logic irq_take = (req_level > mask) || nmi_pending;
   assign irq_lvl = nmi_pending ? NMI_LEVEL : req_level;
   wire logic g2_trap = g2_event.valid && (g2_event.sw_call
      || (g2_event.overflow_check_instruction && g2_event.overflow)
      || (g2_event.bounds_check_instruction && g2_event.out_of_bounds)
      || ((g2_event.signed_divide_instruction
      || g2_event.unsigned_divide_instruction) && g2_event.divisor_zero));
   wire logic [7:0] g2_vec = g2_event.sw_call ? (VEC_TRAP + {4'h0, g2_event.sw_num}) :
      (g2_event.overflow_check_instruction && g2_event.overflow) ? VEC_OVERFLOW_CHECK_INSTRUCTION :
      (g2_event.bounds_check_instruction && g2_event.out_of_bounds) ? VEC_CHK :
      VEC_ZDIV;
   wire logic op_breakpoint_instruction = HAS_BREAKPOINT_INSTRUCTION && ((boundary_op & OP_BREAKPOINT_INSTRUCTION_MASK) == OP_BREAKPOINT_INSTRUCTION);
   wire logic op_linea = (boundary_op[15:12] == LINE_A);
   wire logic op_linef = (boundary_op[15:12] == LINE_F);
   wire logic op_fixed = (boundary_op == OP_ILL_A) || (boundary_op == OP_ILL_B)
      || (boundary_op == OP_ILL_C);
   wire logic op_bad = !chain_q && (op_breakpoint_instruction || op_linea || op_linef || op_fixed
      || !boundary_op_legal);
   wire logic [7:0] op_vec = op_linea ? VEC_LINEA : op_linef ? VEC_LINEF : VEC_ILLEGAL;
   wire logic [1:0] slot = HAS_FMT ? word_q : (word_q + 2'h1);
   wire logic [31:0] vec_addr = vbp_q + (32'(vec_q) << VEC_SHIFT)
      + (32'(word_q) << WORD_SHIFT);
   wire logic [1:0] fetch_last = rst_q ? RST_LAST : VEC_LAST;
   wire logic [15:0] sr_entry = (sr_q | (16'h0001 << SR_S_BIT))
      & ~(16'h0001 << SR_T_BIT);

   logic [15:0] frame_word;
   always_comb begin
      case (slot)
         2'h0: frame_word = {FMT_ZERO, 12'({4'h0, vec_q}) << VEC_SHIFT};
         2'h1: frame_word = pc_save_q[15:0];
         2'h2: frame_word = pc_save_q[31:16];
         default: frame_word = sr_copy_q;
      endcase
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      sr_d = sr_q;
      sr_copy_d = sr_copy_q;
      ssp_d = ssp_q;
      vbp_d = vbp_q;
      vec_d = vec_q;
      pc_save_d = pc_save_q;
      word_d = word_q;
      fetch_d = fetch_q;
      rst_d = rst_q;
      chain_d = chain_q;
      chain_pc_d = chain_pc_q;
      ack_start = 1'b0;
      ack_breakpoint_instruction = 1'b0;
      take_nmi = 1'b0;
      take_trace = 1'b0;
      if (reg_wr && reg_addr == REG_SR) begin
         sr_d = reg_wdata[15:0] & SR_WMASK;
      end else if (reg_wr && reg_addr == REG_SSP) begin
         ssp_d = reg_wdata;
      end else if (reg_wr && reg_addr == REG_VBP && HAS_VBR) begin
         vbp_d = reg_wdata;
      end
      case (state_q)
         ST_IDLE: begin
            chain_d = 1'b0;
            if (g2_trap) begin
               sr_copy_d = sr_q;
               sr_d = sr_entry;
               vec_d = g2_vec;
               pc_save_d = g2_event.pc;
               word_d = 2'h0;
               state_d = ST_PUSH;
            end else if (at_bound && trace_pend_q) begin
               take_trace = 1'b1;
               sr_copy_d = sr_q;
               sr_d = sr_entry;
               vec_d = VEC_TRACE;
               pc_save_d = bpc;
               word_d = 2'h0;
               state_d = ST_PUSH;
            end else if (at_bound && irq_take) begin
               take_nmi = nmi_pending;
               sr_copy_d = sr_q;
               sr_d = sr_entry;
               sr_d[SR_MASK_MSB:SR_MASK_LSB] = irq_lvl;
               pc_save_d = bpc;
               ack_start = 1'b1;
               state_d = ST_IACK;
            end else if (at_bound && op_bad) begin
               sr_copy_d = sr_q;
               sr_d = sr_entry;
               vec_d = op_vec;
               pc_save_d = bpc;
               word_d = 2'h0;
               ack_start = op_breakpoint_instruction;
               ack_breakpoint_instruction = op_breakpoint_instruction;
               state_d = op_breakpoint_instruction ? ST_BREAKPOINT_INSTRUCTION : ST_PUSH;
            end
         end
         ST_IACK: begin
            if (ack_done) begin
               if (ack_res.kind == ACK_SPUR) begin
                  vec_d = VEC_SPUR;
               end else if (ack_res.kind == ACK_AUTO) begin
                  vec_d = VEC_AUTO + {5'h00, mask};
               end else begin
                  vec_d = ack_res.vector;
               end
               word_d = 2'h0;
               state_d = ST_PUSH;
            end
         end
         ST_BREAKPOINT_INSTRUCTION: begin
            if (ack_done) begin
               state_d = ST_PUSH;
            end
         end
         ST_PUSH: begin
            if (mem_done) begin
               ssp_d = ssp_q - WORD_BYTES;
               word_d = word_q + 2'h1;
               if (slot == FRAME_LAST) begin
                  word_d = 2'h0;
                  state_d = ST_VEC;
               end
            end
         end
         ST_VEC: begin
            if (mem_done) begin
               fetch_d = {fetch_q[15:0], mem_rdata};
               word_d = word_q + 2'h1;
               // Stack pointer from first two words
               if (rst_q && word_q == RST_SSP_WORD) begin
                  ssp_d = {fetch_q[15:0], mem_rdata};
               end
               if (word_q == fetch_last) begin
                  word_d = 2'h0;
                  state_d = ST_LOAD;
               end
            end
         end
         ST_LOAD: begin
            rst_d = 1'b0;
            chain_d = 1'b1;
            chain_pc_d = fetch_q;
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      if (g0) begin
         sr_copy_d = sr_q;
         sr_d = sr_entry;
         vec_d = addr_fault ? VEC_ADDR : VEC_BUS;
         pc_save_d = fault_pc;
         word_d = 2'h0;
         rst_d = 1'b0;
         chain_d = 1'b0;
         state_d = ST_PUSH;
      end
   end

   // Fault clear wins over the set; set wins over the take_trace clear
   assign trace_pend_d = !g0 && ((trace_pend_q && !take_trace) || trace_done);
   // Reset instruction only stretches the pin
   assign rcnt_d = reset_instr ? RST_LOAD :
      (rcnt_q != '0) ? (rcnt_q - CW'(1)) : rcnt_q;

   // ----------------------------------------
   // State registers
   // ----------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         // Straight to vector fetch, no frame
         state_q <= ST_VEC;
         rst_q <= 1'b1;
         sr_q <= SR_RST_VAL;
         vbp_q <= 32'h0000_0000;
         vec_q <= VEC_RESET;
         sr_copy_q <= 16'h0000;
         ssp_q <= 32'h0000_0000;
         pc_save_q <= 32'h0000_0000;
         word_q <= 2'h0;
         fetch_q <= 32'h0000_0000;
         chain_q <= 1'b0;
         chain_pc_q <= 32'h0000_0000;
         trace_pend_q <= 1'b0;
         rcnt_q <= '0;
         prst_q <= 1'b0;
      end else if (clk_en) begin
         state_q <= state_d;
         rst_q <= rst_d;
         sr_q <= sr_d;
         vbp_q <= vbp_d;
         vec_q <= vec_d;
         sr_copy_q <= sr_copy_d;
         ssp_q <= ssp_d;
         pc_save_q <= pc_save_d;
         word_q <= word_d;
         fetch_q <= fetch_d;
         chain_q <= chain_d;
         chain_pc_q <= chain_pc_d;
         trace_pend_q <= trace_pend_d;
         rcnt_q <= rcnt_d;
         prst_q <= (rcnt_d != '0);
      end
   end

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   wire logic [31:0] stat_word = {15'h0000, rst_q, state_q, trace_pend_q,
      nmi_pending, vec_q};
   wire logic [31:0] rd_mux = (reg_addr == REG_SR) ? {16'h0000, sr_q} :
      (reg_addr == REG_VBP) ? vbp_q :
      (reg_addr == REG_SSP) ? ssp_q : stat_word;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata_q <= 32'h0000_0000;
      end else if (clk_en) begin
         rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Vector read at base plus number times four
   assign mem_cmd.req = (state_q == ST_PUSH) || (state_q == ST_VEC);
   assign mem_cmd.we = (state_q == ST_PUSH);
   assign mem_cmd.addr = (state_q == ST_PUSH) ? (ssp_q - WORD_BYTES) : vec_addr;
   assign mem_cmd.wdata = (state_q == ST_PUSH) ? frame_word : 16'h0000;
   assign mem_cmd.fc = (state_q == ST_PUSH) ? FC_SUP_DATA : FC_SUP_PROG;
   assign busy = !idle || g2_trap || (at_bound && (trace_pend_q || irq_take || op_bad));
   assign abort = g0;
   assign pc_load = (state_q == ST_LOAD);
   assign new_pc = fetch_q;
   assign status_reg = sr_q;
   assign stack_ptr = ssp_q;
   assign peripheral_reset_out = prst_q;
   assign reg_rdata = rdata_q;
endmodule : ces_sequencer
`default_nettype wire

// >>> bench/ces_chk.sv
`timescale 1ns/10ps
`default_nettype none
module ces_chk import ces_pkg::*; (
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic addr_fault,
   input wire logic bus_fault,
   input wire logic reset_instr,
   input wire logic abort,
   input wire logic [15:0] status_reg,
   input wire logic peripheral_reset_out,
   input wire ces_mem_t mem_cmd,
   input wire logic ack_strobe,
   input wire logic [31:0] ack_addr,
   input wire logic [2:0] function_code_lines
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   property p_rst_sr; $fell(reset) |-> status_reg == SR_RST_VAL; endproperty
   a_rst_sr: assert property (p_rst_sr) else $error("bad sr after reset");
   property p_rst_vec; $fell(reset) |-> mem_cmd.req && mem_cmd.addr == 32'h0
      && mem_cmd.fc == FC_SUP_PROG; endproperty
   a_rst_vec: assert property (p_rst_vec) else $error("bad reset fetch");
   property p_rst_push; $fell(reset) |-> (!(mem_cmd.req && mem_cmd.we)) [*4]; endproperty
   a_rst_push: assert property (p_rst_push) else $error("reset wrote");
   property p_rst_out; reset_instr && clk_en |=> peripheral_reset_out; endproperty
   a_rst_out: assert property (p_rst_out) else $error("no reset pulse");
   property p_irq_sr; ack_strobe && ack_addr != 32'h0 |-> status_reg[SR_S_BIT]
      && !status_reg[SR_T_BIT] && status_reg[10:8] == ack_addr[3:1]; endproperty
   a_irq_sr: assert property (p_irq_sr) else $error("bad sr in ack");
   property p_ack_fc; ack_strobe |-> function_code_lines == FC_CPU
      && ack_addr[31:4] == 28'h0; endproperty
   a_ack_fc: assert property (p_ack_fc) else $error("bad ack cycle");
   property p_abort; abort == (addr_fault || bus_fault); endproperty
   a_abort: assert property (p_abort) else $error("bad abort");
   property p_fault; (addr_fault || bus_fault) && clk_en |-> ##[1:2]
      (mem_cmd.req && mem_cmd.we); endproperty
   a_fault: assert property (p_fault) else $error("late fault entry");
endmodule : ces_chk
`default_nettype wire

// >>> bench/ces_peer.sv
`timescale 1ns/10ps
`default_nettype none
module ces_peer import ces_pkg::*; (
   input wire logic clk,
   input wire logic reset,
   input wire logic [2:0] level,
   input wire logic [1:0] mode,
   input wire logic ack_strobe,
   output logic [2:0] irq_level_n,
   output logic transfer_acknowledge_n,
   output logic peripheral_address_valid_n,
   output logic autovector_request_n,
   output logic bus_error_input_n,
   output logic [7:0] ack_data
);
   logic [3:0] resp_n_q;
   logic [1:0] dly_q;
   assign irq_level_n = ~level;
   assign {transfer_acknowledge_n, peripheral_address_valid_n, autovector_request_n,
      bus_error_input_n} = resp_n_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         resp_n_q <= 4'hF;
         dly_q <= 2'h0;
         ack_data <= 8'h00;
      end else if (!ack_strobe) begin
         resp_n_q <= 4'hF;
         dly_q <= 2'h0;
         ack_data <= ~ack_data;
      end else if (dly_q != 2'h2) begin
         dly_q <= dly_q + 2'h1;
      end else begin
         resp_n_q <= mode == 2'h1 ? 4'hD : mode == 2'h2 ? 4'hE : 4'h7;
         ack_data <= mode == 2'h3 ? 8'h0F : 8'h40;
      end
   end
endmodule : ces_peer
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench import ces_pkg::*;;
   logic clk, reset, clk_en, boundary, boundary_op_legal, trace_done, addr_fault, bus_fault;
   logic reset_instr, busy, abort, pc_load, peripheral_reset_out, mem_done, ack_strobe;
   logic transfer_acknowledge_n, peripheral_address_valid_n, autovector_request_n;
   logic bus_error_input_n, reg_wr, reg_rd, wr_seen;
   logic [31:0] boundary_pc, fault_pc, new_pc, stack_ptr, ack_addr, reg_wdata, reg_rdata, va, vbp;
   logic [15:0] boundary_op, status_reg, mem_rdata, fo;
   logic [7:0] ack_data;
   logic [2:0] irq_level_n, function_code_lines, level;
   logic [1:0] reg_addr, mode;
   ces_g2_t g2_event, g;
   ces_mem_t mem_cmd;
   int seed = 21186, failures = 0, n_compared = 0, n_wr = 0;
   logic [7:0] iv [4] = '{8'h40, VEC_AUTO + 8'h03, VEC_SPUR, 8'h0F};
   logic [15:0] ops [7] = '{16'h4AFA, 16'h4AFB, 16'h4AFC, 16'h484D, 16'hA123, 16'hF0F0, 16'h0FFF};
   logic [7:0] ovs [7] = '{VEC_ILLEGAL, VEC_ILLEGAL, VEC_ILLEGAL, VEC_ILLEGAL, VEC_LINEA,
      VEC_LINEF, VEC_ILLEGAL};
   ces_sequencer #(.RST_OUT_CYCLES(2)) u_dut (.*);
   ces_peer u_peer (.*);
   function automatic logic [15:0] mw(input logic [31:0] a);
      return a[15:0] ^ 16'hC3A5;
   endfunction : mw
   // --------------------------------
   // Memory with random wait
   // --------------------------------
   always @(posedge clk) begin
      mem_done <= !reset && mem_cmd.req && !mem_done && ($random(seed) & 1) == 1;
      mem_rdata <= mw(mem_cmd.addr);
      if (mem_done && mem_cmd.we && !wr_seen) fo <= mem_cmd.wdata;
      if (mem_done && mem_cmd.we) wr_seen <= 1'b1;
      if (mem_done && mem_cmd.we) n_wr++;
      if (mem_done && !mem_cmd.we && wr_seen) va <= mem_cmd.addr;
      if (mem_done && !mem_cmd.we && wr_seen) wr_seen <= 1'b0;
   end
   task automatic stop_test;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wait_load;
      int i = 0;
      do begin @(negedge clk); i++; end while (pc_load !== 1'b1 && i < 500);
      if (i >= 500) begin failures++; stop_test; end
   endtask : wait_load
   task automatic wr(input logic [1:0] a, input logic [31:0] d);
      @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk) reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [1:0] a, input logic [31:0] e);
      @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk) reg_rd <= 1'b0;
      @(negedge clk) chk("reg_rdata", e, reg_rdata);
   endtask : rd
   task automatic do_reset;
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      n_wr = 0;
      reset <= 1'b0;
      wait_load;
      chk("stack pointer", {mw(0), mw(2)}, stack_ptr);
      chk("start pc", {mw(4), mw(6)}, new_pc);
      chk("reset writes", 0, n_wr);
      rd(REG_SR, {16'h0, SR_RST_VAL});
   endtask : do_reset
   task automatic run(input int k, input ces_g2_t t, input logic [15:0] op, input logic [7:0] ev);
      wr(REG_SR, 32'h2000);
      @(posedge clk);
      boundary_pc <= $random(seed);
      {boundary_op, boundary_op_legal} <= {op, op == 16'h4E71};
      if (k == 0) boundary <= 1'b1;
      if (k == 1) g2_event <= t;
      {addr_fault, bus_fault} <= {k == 2, k == 3};
      @(posedge clk) {boundary, addr_fault, bus_fault, g2_event} <= '0;
      wait_load;
      chk("vector address", vbp + {ev, 2'b00}, va);
      if (k < 2) chk("format word", {ev, 2'b00}, fo);
      level <= 3'h0;
      repeat (6) @(posedge clk);
   endtask : run
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      {reset, clk_en} = 2'b11;
      {boundary, boundary_op_legal, trace_done, addr_fault, bus_fault, reset_instr} = '0;
      {reg_wr, reg_rd, wr_seen, mem_done, level, mode, reg_addr, reg_wdata} = '0;
      {g2_event, boundary_op, mem_rdata, boundary_pc} = '0;
      fault_pc = $random(seed);
      do_reset;
      rd(REG_VBP, 32'h0);
      vbp = $random(seed) & 32'hFFF0;
      wr(REG_VBP, vbp);
      wr(REG_SR, 32'h2300);
      level <= 3'h3;
      repeat (6) @(posedge clk);
      {boundary, boundary_op, boundary_op_legal} <= {1'b1, 16'h4E71, 1'b1};
      @(negedge clk) chk("masked busy", 0, busy);
      @(posedge clk) boundary <= 1'b0;
      for (int m = 0; m < 4; m++) begin
         {mode, level} <= {2'(m), 3'h3};
         repeat (6) @(posedge clk);
         run(0, '0, 16'h4E71, iv[m]);
      end
      g = '0;
      {g.valid, g.sw_call, g.sw_num, g.pc} = {2'b11, 4'($random(seed)), 32'($random(seed))};
      run(1, g, 16'h0, VEC_TRAP + g.sw_num);
      {g.sw_call, g.overflow_check_instruction, g.overflow} = 3'b011;
      run(1, g, 16'h0, VEC_OVERFLOW_CHECK_INSTRUCTION);
      {g.overflow_check_instruction, g.bounds_check_instruction, g.out_of_bounds} = 3'b011;
      run(1, g, 16'h0, VEC_CHK);
      {g.bounds_check_instruction, g.signed_divide_instruction, g.divisor_zero} = 3'b011;
      run(1, g, 16'h0, VEC_ZDIV);
      foreach (ops[i]) run(0, '0, ops[i], ovs[i]);
      run(2, '0, 16'h0, VEC_ADDR);
      run(3, '0, 16'h0, VEC_BUS);
      @(posedge clk) reset_instr <= 1'b1;
      @(posedge clk) reset_instr <= 1'b0;
      @(negedge clk) chk("peripheral reset", 1, peripheral_reset_out);
      @(posedge clk) g2_event <= g;
      @(posedge clk) g2_event <= '0;
      repeat (2) @(posedge clk);
      do_reset;
      stop_test;
   end
endmodule : testbench
bind ces_sequencer ces_chk u_chk (.*);
`default_nettype wire
